/* core/pspc_config_loader.sv */
// Start-up configuration loader: rotary switch decode, protocol storage,
// per-port channel mode restore and fault/supply indicator drive.
// Assumes a non-volatile memory controller beside it on the same clock and
// switch pins that arrive asynchronously.
`timescale 1ns/1ns

// Behaviour
// - Hundreds switch selects protocol; 0-2 is EtherNet/IP.
// - EtherNet/IP takes hundreds switch as hundreds digit.
// - Tens and units switches give the low digits.
// - PROFINET position ignores tens and units switches.
// - Without stored protocol, adopt switch selection.
// - Switch changes adopted only at power cycle/reset command.
// - Store protocol when cyclic communication first starts.
// - Stored protocol overrides switch until factory reset.
// - Invalid switch combination lights bus fault red.
// - New protocol initialises 15 s, indicators dark.
// - Code 9-7-9 at start performs factory reset.
// - Supply indicator blinks red during factory reset.
// - Ports one to eight map to sub-slots 2-9.
// - Channels default to digital input mode.
// - Deactivated mode switches off port sensor supply.
// - IO-Link mode starts communication with attached device.
// - Stored port configuration applied at power-up.
// - I/O data invalid until controller configuration arrives.
module pspc_config_loader
	import pspc_pkg::*;
#(
	parameter logic [31:0] INIT_CYCLES  = PSPC_INIT_CYCLES,
	parameter logic [31:0] BLINK_CYCLES = PSPC_BLINK_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [3:0]  hundredsSwitch,
	input  wire logic [3:0]  tensSwitch,
	input  wire logic [3:0]  unitsSwitch,
	input  wire logic        webResetCmd,
	input  wire logic        cyclicStart,
	input  wire logic        nvmProtoValid,
	input  wire logic [2:0]  nvmProto,
	input  wire logic        nvmPortCfgValid,
	input  wire logic [15:0] nvmPortMode,
	input  wire logic        nvmDone,
	input  wire logic        ctrlCfgValid,
	input  wire logic [15:0] ctrlPortMode,
	input  wire logic        usSupplyGood,
	output logic [2:0]       protocolSel,
	output logic [3:0]       ipHundreds,
	output logic [3:0]       ipTens,
	output logic [3:0]       ipUnits,
	output logic             ipAddrValid,
	output logic             busFaultRed,
	output logic             usLedGreen,
	output logic             usLedRed,
	output logic             deviceReady,
	output logic             factoryBusy,
	output logic             nvmClearReq,
	output logic             nvmProtoWrite,
	output logic             nvmPortSave,
	output logic [15:0]      portMode,
	output logic [7:0]       portSupplyOn,
	output logic [7:0]       ioLinkStart,
	output logic [31:0]      portSubslot,
	output logic             ioDataValid
);

	// Whole module state in one packed struct.
	typedef struct packed {
		pspc_state_t st;         // Controller state.
		logic [3:0]  hSync1;     // First synchroniser stages, read only by the second.
		logic [3:0]  tSync1;
		logic [3:0]  uSync1;
		logic [3:0]  hSync2;     // Second synchroniser stages.
		logic [3:0]  tSync2;
		logic [3:0]  uSync2;
		pspc_proto_t proto;      // Protocol in use.
		logic [3:0]  ipH;        // Latched address digits.
		logic [3:0]  ipT;
		logic [3:0]  ipU;
		logic        ipValid;    // Digits are meaningful for the protocol.
		logic        stored;     // Protocol held in non-volatile memory.
		logic        fault;      // Invalid switch combination seen at sampling.
		logic [31:0] cnt;        // Settle and initialisation counter.
		logic [31:0] blinkCnt;   // Blink half-period counter.
		logic        blink;      // Blink phase.
		logic [15:0] mode;       // Per-port channel mode.
		logic        ioValid;    // I/O data valid flag.
		logic        clr;        // Request strobes: clr and wrProto last one cycle, wrPort follows ctrlCfgValid while running.
		logic        wrProto;
		logic        wrPort;
	} pspc_regs_t;

	pspc_regs_t  s;          // Registered state.
	pspc_regs_t  next_s;     // Next state.
	pspc_proto_t swProto;    // Protocol decoded from the synchronised hundreds switch.
	logic        swFactory;  // Factory reset code on all three switches.
	logic        digitsBad;  // Tens or units switch out of 0-9, or hundreds switch above 2 under EtherNet/IP.
	logic        usesDigits; // Effective protocol takes address digits.
	pspc_proto_t effProto;   // Stored protocol if any, otherwise the switch choice.

	// Decode of the synchronised switches, read only in the sampling state.
	always_comb begin
		if (s.hSync2 <= PSPC_POS_EIP_MAX) begin
			swProto = PSPC_PROTO_EIP;
		end else begin
			case (s.hSync2)
				PSPC_POS_PN: swProto = PSPC_PROTO_PN;
				PSPC_POS_EC: swProto = PSPC_PROTO_EC;
				PSPC_POS_MB: swProto = PSPC_PROTO_MB;
				PSPC_POS_CC: swProto = PSPC_PROTO_CC;
				default: swProto = PSPC_PROTO_NONE;
			endcase
		end
		swFactory = (s.hSync2 == PSPC_FR_HUNDREDS) && (s.tSync2 == PSPC_FR_TENS)
			&& (s.uSync2 == PSPC_FR_UNITS);
		// A stored protocol wins over the switch; the switch only adds digits.
		effProto = nvmProtoValid ? pspc_proto_t'(nvmProto) : swProto;
		usesDigits = (effProto == PSPC_PROTO_EIP) || (effProto == PSPC_PROTO_MB)
			|| (effProto == PSPC_PROTO_CC);
		digitsBad = (s.tSync2 > PSPC_DIGIT_MAX) || (s.uSync2 > PSPC_DIGIT_MAX)
			|| ((effProto == PSPC_PROTO_EIP) && (s.hSync2 > PSPC_POS_EIP_MAX));
	end

	// Next-state logic for the whole module.
	always_comb begin
		next_s = s;
		next_s.hSync1 = hundredsSwitch;
		next_s.tSync1 = tensSwitch;
		next_s.uSync1 = unitsSwitch;
		next_s.hSync2 = s.hSync1;
		next_s.tSync2 = s.tSync1;
		next_s.uSync2 = s.uSync1;
		next_s.clr = 1'b0;
		next_s.wrProto = 1'b0;
		next_s.wrPort = 1'b0;
		next_s.blinkCnt = 32'h0000_0000;
		next_s.blink = 1'b0;
		case (s.st)
			// Let the synchronisers fill before the one-time sample.
			PSPC_ST_SYNC: begin
				next_s.ioValid = 1'b0;
				if (s.cnt == PSPC_SYNC_SETTLE) begin
					next_s.st = PSPC_ST_SAMPLE;
					next_s.cnt = 32'h0000_0000;
				end else begin
					next_s.cnt = s.cnt + 32'h0000_0001;
				end
			end
			// Sample once; the result then holds until the next restart.
			PSPC_ST_SAMPLE: begin
				next_s.ipH = s.hSync2;
				next_s.ipT = s.tSync2;
				next_s.ipU = s.uSync2;
				if (swFactory) begin
					next_s.st = PSPC_ST_FACTORY;
					next_s.clr = 1'b1;
					next_s.stored = 1'b0;
					next_s.proto = PSPC_PROTO_NONE;
					next_s.fault = 1'b0;
					next_s.ipValid = 1'b0;
					next_s.mode = PSPC_PORT_MODE_RST;
				end else begin
					next_s.proto = effProto;
					next_s.stored = nvmProtoValid;
					next_s.fault = (effProto == PSPC_PROTO_NONE) || (usesDigits && digitsBad);
					next_s.ipValid = usesDigits && !digitsBad;
					if (effProto != PSPC_PROTO_EIP) begin
						next_s.ipH = 4'h0;
					end
					// Stored port setup is applied before any controller setup.
					next_s.mode = nvmPortCfgValid ? nvmPortMode : PSPC_PORT_MODE_RST;
					// A freshly chosen protocol needs its stack brought up first.
					next_s.st = nvmProtoValid ? PSPC_ST_RUN : PSPC_ST_INIT;
				end
			end
			// Wait for memory to finish clearing while the supply indicator blinks.
			PSPC_ST_FACTORY: begin
				if (s.blinkCnt == BLINK_CYCLES - 32'h0000_0001) begin
					next_s.blink = !s.blink;
				end else begin
					next_s.blinkCnt = s.blinkCnt + 32'h0000_0001;
					next_s.blink = s.blink;
				end
				if (nvmDone) begin
					next_s.st = PSPC_ST_RUN;
				end
			end
			// Protocol initialisation: unusable, indicators dark.
			PSPC_ST_INIT: begin
				if (s.cnt == INIT_CYCLES - 32'h0000_0001) begin
					next_s.st = PSPC_ST_RUN;
					next_s.cnt = 32'h0000_0000;
				end else begin
					next_s.cnt = s.cnt + 32'h0000_0001;
				end
			end
			// Normal operation.
			PSPC_ST_RUN: begin
				if (webResetCmd) begin
					next_s.st = PSPC_ST_SYNC;
					next_s.cnt = 32'h0000_0000;
					next_s.ioValid = 1'b0;
				end else begin
					if (cyclicStart && !s.stored && (s.proto != PSPC_PROTO_NONE) && !s.fault) begin
						next_s.wrProto = 1'b1;
						next_s.stored = 1'b1;
					end
					if (ctrlCfgValid) begin
						next_s.mode = ctrlPortMode;
						next_s.ioValid = 1'b1;
						next_s.wrPort = 1'b1;
					end
				end
			end
			default: begin
				next_s.st = PSPC_ST_SYNC;
				next_s.cnt = 32'h0000_0000;
			end
		endcase
	end

	// Synchronous reset to all zeros: sync state, no protocol, every channel a digital input.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Outputs from the state register; the supply indicators also take usSupplyGood directly.
	assign protocolSel   = s.proto;
	assign ipHundreds    = s.ipH;
	assign ipTens        = s.ipT;
	assign ipUnits       = s.ipU;
	assign ipAddrValid   = s.ipValid;
	assign deviceReady   = (s.st == PSPC_ST_RUN);
	assign factoryBusy   = (s.st == PSPC_ST_FACTORY);
	assign busFaultRed   = s.fault && (s.st == PSPC_ST_RUN);
	assign usLedRed      = (s.st == PSPC_ST_FACTORY) ? s.blink
		: ((s.st == PSPC_ST_RUN) && !usSupplyGood);
	assign usLedGreen    = (s.st == PSPC_ST_RUN) && usSupplyGood;
	assign nvmClearReq   = s.clr;
	assign nvmProtoWrite = s.wrProto;
	assign nvmPortSave   = s.wrPort;
	assign portMode      = s.mode;
	assign ioDataValid   = s.ioValid;

	// Per-port supply, IO-Link start and sub-slot numbering.
	for (genvar p = 0; p < PSPC_PORTS; p++) begin : g_port
		assign portSupplyOn[p] = (s.mode[2*p +: 2] != PSPC_MODE_DEACT);
		assign ioLinkStart[p]  = (s.mode[2*p +: 2] == PSPC_MODE_IOLINK) && deviceReady;
		assign portSubslot[4*p +: 4] = PSPC_FIRST_SUBSLOT + 4'(p);
	end

	// Checks on the decode, storage and indicator behaviour.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_eip_select;
		(s.st == PSPC_ST_SAMPLE) && !swFactory && !nvmProtoValid && (s.hSync2 <= 4'h2)
			|=> (protocolSel == PSPC_PROTO_EIP) && (ipHundreds == $past(s.hSync2));
	endproperty
	a_eip_select: assert property (p_eip_select) else $error("EIP decode wrong");

	property p_pn_select;
		(s.st == PSPC_ST_SAMPLE) && !nvmProtoValid && (s.hSync2 == PSPC_POS_PN)
			|=> (protocolSel == PSPC_PROTO_PN) && !ipAddrValid && !s.fault;
	endproperty
	a_pn_select: assert property (p_pn_select) else $error("PROFINET decode wrong");

	property p_digits;
		(s.st == PSPC_ST_SAMPLE) && !swFactory && (effProto == PSPC_PROTO_MB) && !digitsBad
			|=> ipAddrValid && (ipTens == $past(s.tSync2)) && (ipUnits == $past(s.uSync2));
	endproperty
	a_digits: assert property (p_digits) else $error("address digits wrong");

	property p_stored_wins;
		(s.st == PSPC_ST_SAMPLE) && !swFactory && nvmProtoValid
			|=> (protocolSel == $past(nvmProto)) && (s.st == PSPC_ST_RUN);
	endproperty
	a_stored_wins: assert property (p_stored_wins) else $error("stored protocol lost");

	property p_hold;
		(s.st == PSPC_ST_RUN) && !webResetCmd |=> $stable(protocolSel) && $stable(ipTens);
	endproperty
	a_hold: assert property (p_hold) else $error("selection changed while running");

	property p_store;
		(s.st == PSPC_ST_RUN) && !webResetCmd && cyclicStart && !s.stored
			&& (s.proto != PSPC_PROTO_NONE) && !s.fault |=> nvmProtoWrite ##1 !nvmProtoWrite;
	endproperty
	a_store: assert property (p_store) else $error("protocol not stored");

	property p_init_dark;
		(s.st == PSPC_ST_INIT) |-> !busFaultRed && !usLedGreen && !usLedRed && !deviceReady;
	endproperty
	a_init_dark: assert property (p_init_dark) else $error("indicators lit in init");

	property p_factory;
		(s.st == PSPC_ST_SAMPLE) && swFactory |=> nvmClearReq && factoryBusy ##1 !nvmClearReq;
	endproperty
	a_factory: assert property (p_factory) else $error("factory reset not started");

	property p_factory_led;
		factoryBusy |-> !usLedGreen;
	endproperty
	a_factory_led: assert property (p_factory_led) else $error("green during factory");

	property p_deact;
		(s.st == PSPC_ST_RUN) && !webResetCmd && ctrlCfgValid
			&& (ctrlPortMode[1:0] == PSPC_MODE_DEACT) |=> !portSupplyOn[0] && ioDataValid;
	endproperty
	a_deact: assert property (p_deact) else $error("supply left on");

	property p_restore;
		(s.st == PSPC_ST_SAMPLE) && !swFactory |=> portMode ==
			($past(nvmPortCfgValid) ? $past(nvmPortMode) : PSPC_PORT_MODE_RST);
	endproperty
	a_restore: assert property (p_restore) else $error("port setup not restored");

	property p_invalid_io;
		(s.st == PSPC_ST_SYNC) |=> !ioDataValid;
	endproperty
	a_invalid_io: assert property (p_invalid_io) else $error("I/O valid too early");

	property p_subslot;
		(portSubslot[3:0] == 4'h2) && (portSubslot[31:28] == 4'h9);
	endproperty
	a_subslot: assert property (p_subslot) else $error("sub-slot map wrong");

	c_factory: cover property ((s.st == PSPC_ST_FACTORY) ##1 (s.st == PSPC_ST_RUN));
	c_init_done: cover property ((s.st == PSPC_ST_INIT) ##1 (s.st == PSPC_ST_RUN));
	c_store: cover property (nvmProtoWrite);
	c_ctrl_cfg: cover property ($rose(ioDataValid));

endmodule

/* include/pspc_pkg.sv */
// Package for the protocol switch and port configuration loader.
// Assumes a 125 MHz system clock and hex rotary switches giving 4-bit codes.
package pspc_pkg;

	// Controller states, binary codes written out.
	typedef enum logic [2:0] {
		PSPC_ST_SYNC    = 3'h0,
		PSPC_ST_SAMPLE  = 3'h1,
		PSPC_ST_FACTORY = 3'h2,
		PSPC_ST_INIT    = 3'h3,
		PSPC_ST_RUN     = 3'h4
	} pspc_state_t;

	// Protocol selection codes as driven out and stored in non-volatile memory.
	typedef enum logic [2:0] {
		PSPC_PROTO_NONE = 3'h0,
		PSPC_PROTO_EIP  = 3'h1,
		PSPC_PROTO_PN   = 3'h2,
		PSPC_PROTO_EC   = 3'h3,
		PSPC_PROTO_MB   = 3'h4,
		PSPC_PROTO_CC   = 3'h5
	} pspc_proto_t;

	// Channel modes, two bits per port.
	localparam logic [1:0] PSPC_MODE_DIGIN  = 2'h0;
	localparam logic [1:0] PSPC_MODE_DO     = 2'h1;
	localparam logic [1:0] PSPC_MODE_DEACT  = 2'h2;
	localparam logic [1:0] PSPC_MODE_IOLINK = 2'h3;

	// Hundreds switch positions.
	localparam logic [3:0] PSPC_POS_EIP_MAX = 4'h2;
	localparam logic [3:0] PSPC_POS_PN      = 4'hA;
	localparam logic [3:0] PSPC_POS_EC      = 4'hB;
	localparam logic [3:0] PSPC_POS_MB      = 4'hC;
	localparam logic [3:0] PSPC_POS_CC      = 4'hD;
	localparam logic [3:0] PSPC_DIGIT_MAX   = 4'h9;

	// Factory reset code on the three switches.
	localparam logic [3:0] PSPC_FR_HUNDREDS = 4'h9;
	localparam logic [3:0] PSPC_FR_TENS     = 4'h7;
	localparam logic [3:0] PSPC_FR_UNITS    = 4'h9;

	// Port count, sub-slot of the first port.
	localparam int         PSPC_PORTS         = 8;
	localparam logic [3:0] PSPC_FIRST_SUBSLOT = 4'h2;
	localparam logic [15:0] PSPC_PORT_MODE_RST = 16'h0000;

	// Timing: clock rate in kHz, times in ms, derived cycle counts (rounded down).
	localparam longint PSPC_CLK_KHZ       = 125000;
	localparam longint PSPC_INIT_TIME_MS  = 15000;
	localparam longint PSPC_BLINK_TIME_MS = 250;
	localparam logic [31:0] PSPC_INIT_CYCLES  = 32'(PSPC_INIT_TIME_MS * PSPC_CLK_KHZ);
	localparam logic [31:0] PSPC_BLINK_CYCLES = 32'(PSPC_BLINK_TIME_MS * PSPC_CLK_KHZ);
	localparam logic [31:0] PSPC_SYNC_SETTLE  = 32'h0000_0002;

endpackage

/* testbench/pspc_config_loader_tb.sv */
// Self-checking bench for the start-up configuration loader.
// Assumes the store model beside it and shortened initialisation and blink counts.
`timescale 1ns/1ns
module pspc_config_loader_tb;
	import pspc_pkg::*;
	localparam int INIT = 20;  // Shortened initialisation time in cycles.
	logic        clk_sys = 1'b0;
	logic        rst_n, webResetCmd, cyclicStart, ctrlCfgValid, usSupplyGood, slowDone;
	logic [3:0]  hundredsSwitch, tensSwitch, unitsSwitch, h, t, u;
	logic [15:0] ctrlPortMode, m1, m2;
	logic        nvmProtoValid, nvmPortCfgValid, nvmDone, nvmClearReq, nvmProtoWrite;
	logic [2:0]  nvmProto, protocolSel;
	logic [15:0] nvmPortMode, portMode;
	logic [3:0]  ipHundreds, ipTens, ipUnits;
	logic        ipAddrValid, busFaultRed, usLedGreen, usLedRed, deviceReady, factoryBusy;
	logic        nvmPortSave, ioDataValid, dark, addrOk, prevRed;
	logic [7:0]  portSupplyOn, ioLinkStart;
	logic [31:0] portSubslot;
	int          num_errors = 0, n_compared = 0, cycles = 0, n, blinks;
	always #4 clk_sys = ~clk_sys;
	pspc_config_loader #(.INIT_CYCLES(32'(INIT)), .BLINK_CYCLES(32'h0000_0004))
	pspc_config_loader_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hundredsSwitch(hundredsSwitch),
		.tensSwitch(tensSwitch), .unitsSwitch(unitsSwitch), .webResetCmd(webResetCmd),
		.cyclicStart(cyclicStart), .nvmProtoValid(nvmProtoValid), .nvmProto(nvmProto),
		.nvmPortCfgValid(nvmPortCfgValid), .nvmPortMode(nvmPortMode), .nvmDone(nvmDone),
		.ctrlCfgValid(ctrlCfgValid), .ctrlPortMode(ctrlPortMode), .usSupplyGood(usSupplyGood),
		.protocolSel(protocolSel), .ipHundreds(ipHundreds), .ipTens(ipTens), .ipUnits(ipUnits),
		.ipAddrValid(ipAddrValid), .busFaultRed(busFaultRed), .usLedGreen(usLedGreen),
		.usLedRed(usLedRed), .deviceReady(deviceReady), .factoryBusy(factoryBusy),
		.nvmClearReq(nvmClearReq), .nvmProtoWrite(nvmProtoWrite), .nvmPortSave(nvmPortSave),
		.portMode(portMode), .portSupplyOn(portSupplyOn), .ioLinkStart(ioLinkStart),
		.portSubslot(portSubslot), .ioDataValid(ioDataValid));
	pspc_nvm_model pspc_nvm_model_inst (.clk_sys(clk_sys), .slowDone(slowDone),
		.nvmClearReq(nvmClearReq), .nvmProtoWrite(nvmProtoWrite), .protocolSel(protocolSel),
		.nvmPortSave(nvmPortSave), .portMode(portMode), .nvmProtoValid(nvmProtoValid),
		.nvmProto(nvmProto), .nvmPortMode(nvmPortMode), .nvmPortCfgValid(nvmPortCfgValid),
		.nvmDone(nvmDone));
	// Prints the counts and the verdict, then stops the run.
	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Compares one value against its expectation; an unknown bit matches only the same unknown in the expectation.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Moves to just after the next rising edge, where inputs change and outputs are settled.
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	// Expected protocol for a hundreds position.
	function automatic logic [2:0] expProto(input logic [3:0] hs);
		if (hs <= PSPC_POS_EIP_MAX) begin
			return PSPC_PROTO_EIP;
		end
		case (hs)
			PSPC_POS_PN: return PSPC_PROTO_PN;
			PSPC_POS_EC: return PSPC_PROTO_EC;
			PSPC_POS_MB: return PSPC_PROTO_MB;
			PSPC_POS_CC: return PSPC_PROTO_CC;
			default:     return PSPC_PROTO_NONE;
		endcase
	endfunction
	// True where the protocol takes address digits from the switches.
	function automatic logic usesDigits(input logic [2:0] p);
		return p == PSPC_PROTO_EIP || p == PSPC_PROTO_MB || p == PSPC_PROTO_CC;
	endfunction
	// Expected fault: no protocol, or an addressed protocol with a digit above nine.
	function automatic logic expFault(input logic [3:0] hs, input logic [3:0] ts,
		input logic [3:0] us);
		return expProto(hs) == PSPC_PROTO_NONE ||
			(usesDigits(expProto(hs)) && (ts > PSPC_DIGIT_MAX || us > PSPC_DIGIT_MAX));
	endfunction
	// One bit per port set where that port's mode equals the given code.
	function automatic logic [7:0] modeIs(input logic [15:0] m, input logic [1:0] code);
		for (int i = 0; i < 8; i++) begin
			modeIs[i] = (m[2*i +: 2] == code);
		end
	endfunction
	// Resets with the given switches and waits until running or clearing; n counts edges.
	task automatic restart(input logic [3:0] hs, input logic [3:0] ts, input logic [3:0] us);
		rst_n = 1'b0;
		hundredsSwitch = hs;
		tensSwitch = ts;
		unitsSwitch = us;
		tick();
		tick();
		rst_n = 1'b1;
		dark = 1'b1;
		n = 0;
		while (deviceReady !== 1'b1 && factoryBusy !== 1'b1 && n < 200) begin
			tick();
			n++;
			if (deviceReady !== 1'b1 && factoryBusy !== 1'b1 &&
				(usLedGreen | usLedRed | busFaultRed) !== 1'b0) begin
				dark = 1'b0;
			end
		end
	endtask
	// Checks the outputs that follow a controller configuration.
	task automatic chkCfg(input logic [15:0] m);
		chk(32'(portMode), 32'(m));
		chk(32'(nvmPortSave), 32'h0000_0001);
		chk(32'(ioDataValid), 32'h0000_0001);
		chk(32'(portSupplyOn), 32'(8'(~modeIs(m, PSPC_MODE_DEACT))));
		chk(32'(ioLinkStart), 32'(modeIs(m, PSPC_MODE_IOLINK)));
	endtask
	// A hang counts as a mismatch and ends the run.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// Main sequence: fresh decode sweep, live changes, storage, restarts, factory clear.
	initial begin
		{rst_n, webResetCmd, cyclicStart, ctrlCfgValid, slowDone} = 5'h00;
		{hundredsSwitch, tensSwitch, unitsSwitch} = 12'h000;
		ctrlPortMode = 16'h0000;
		usSupplyGood = 1'b1;
		n = $urandom(32'h0000_4f77);
		for (int i = 0; i < 16; i++) begin
			h = 4'(i);
			// Even positions keep legal digits so addressed positions 0, 2 and C decode cleanly; 1 and D may not.
			t = 4'($urandom_range(i[0] ? 15 : 9));
			u = 4'($urandom_range(i[0] ? 15 : 9));
			if (h == PSPC_FR_HUNDREDS && t == PSPC_FR_TENS) t = 4'h6;
			restart(h, t, u);
			addrOk = usesDigits(expProto(h)) && !expFault(h, t, u);
			chk(32'(n >= INIT && n <= INIT + 8), 32'h0000_0001);
			chk(32'(dark), 32'h0000_0001);
			chk(32'(protocolSel), 32'(expProto(h)));
			chk(32'(busFaultRed), 32'(expFault(h, t, u)));
			chk(32'(ipAddrValid), 32'(addrOk));
			chk(32'(ipHundreds), (expProto(h) == PSPC_PROTO_EIP) ? 32'(h) : 32'h0);
			if (addrOk) chk(32'({ipTens, ipUnits}), 32'({t, u}));
			chk(32'(portMode), 32'(PSPC_PORT_MODE_RST));
			chk(portSubslot, 32'h9876_5432);
			chk(32'(ioDataValid), 32'h0000_0000);
		end
		t = 4'($urandom_range(9));
		u = 4'($urandom_range(9));
		restart(4'h1, t, u);
		hundredsSwitch = PSPC_POS_PN;
		tensSwitch = ~t;
		repeat (8) tick();
		chk(32'(protocolSel), 32'(PSPC_PROTO_EIP));
		chk(32'({ipHundreds, ipTens, ipUnits}), 32'({4'h1, t, u}));
		// Only mode codes reach the block; the data length pick stays with the controller.
		m1 = 16'($urandom);
		// The second word puts port one in deactivated mode and the next three in the others.
		m2 = {8'($urandom), 8'h1E};
		ctrlCfgValid = 1'b1;
		ctrlPortMode = m1;
		tick();
		ctrlPortMode = m2;
		chkCfg(m1);
		tick();
		ctrlCfgValid = 1'b0;
		chkCfg(m2);
		tick();
		chk(32'(nvmPortSave), 32'h0000_0000);
		for (int k = 0; k < 2; k++) begin
			cyclicStart = 1'b1;
			tick();
			cyclicStart = 1'b0;
			chk(32'(nvmProtoWrite), 32'(k == 0));
			tick();
			chk(32'(nvmProtoWrite), 32'h0000_0000);
		end
		restart(PSPC_POS_PN, 4'h5, 4'h3);
		chk(32'(n <= 8), 32'h0000_0001);
		chk(32'(protocolSel), 32'(PSPC_PROTO_EIP));
		chk(32'(busFaultRed), 32'h0000_0001);
		chk(32'(portMode), 32'(m2));
		chk(32'(portSupplyOn), 32'(8'(~modeIs(m2, PSPC_MODE_DEACT))));
		chk(32'(ioDataValid), 32'h0000_0000);
		restart(4'h2, 4'h5, 4'h3);
		chk(32'({ipHundreds, ipTens, ipUnits}), 32'h0000_0253);
		tensSwitch = 4'h8;
		webResetCmd = 1'b1;
		tick();
		webResetCmd = 1'b0;
		chk(32'(deviceReady), 32'h0000_0000);
		repeat (30) if (deviceReady !== 1'b1) tick();
		chk(32'(ipTens), 32'h0000_0008);
		slowDone = 1'b1;
		usSupplyGood = 1'($urandom_range(1));
		restart(PSPC_FR_HUNDREDS, PSPC_FR_TENS, PSPC_FR_UNITS);
		chk(32'({factoryBusy, nvmClearReq}), 32'h0000_0003);
		blinks = 0;
		prevRed = usLedRed;
		n = 0;
		while (factoryBusy === 1'b1 && n < 200) begin
			tick();
			n++;
			if (usLedRed !== prevRed) blinks++;
			prevRed = usLedRed;
		end
		chk(32'(blinks >= 2), 32'h0000_0001);
		chk(32'({usLedGreen, usLedRed}), 32'({usSupplyGood, !usSupplyGood}));
		chk(32'(protocolSel), 32'(PSPC_PROTO_NONE));
		restart(PSPC_POS_PN, 4'h3, 4'h3);
		chk(32'(n >= INIT), 32'h0000_0001);
		chk(32'({protocolSel, ipAddrValid}), 32'({PSPC_PROTO_PN, 1'b0}));
		conclude();
	end
endmodule

/* testbench/pspc_nvm_model.sv */
// Behavioural model of the non-volatile store that faces the configuration loader.
// Assumes the loader's one-cycle clear and protocol write pulses and level-held port saves on the shared system clock.
`timescale 1ns/1ns
module pspc_nvm_model
	import pspc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        slowDone,
	input  wire logic        nvmClearReq,
	input  wire logic        nvmProtoWrite,
	input  wire logic [2:0]  protocolSel,
	input  wire logic        nvmPortSave,
	input  wire logic [15:0] portMode,
	output logic             nvmProtoValid,
	output logic [2:0]       nvmProto,
	output logic [15:0]      nvmPortMode,
	output logic             nvmPortCfgValid,
	output logic             nvmDone
);
	logic [2:0]  storedProto = 3'h5;      // Stored protocol code.
	logic [15:0] storedMode  = 16'hA5C3;  // Stored port modes.
	logic [7:0]  doneCnt     = 8'h00;     // Cycles left of a clear.
	// The store is non-volatile, so it starts empty and ignores the loader's reset.
	initial begin
		nvmProtoValid   = 1'b0;
		nvmPortCfgValid = 1'b0;
		nvmDone         = 1'b0;
	end
	// Empty slots show inverted garbage so the loader cannot lean on stale zeros.
	assign nvmProto    = nvmProtoValid ? storedProto : ~storedProto;
	assign nvmPortMode = nvmPortCfgValid ? storedMode : ~storedMode;
	// Writes land one edge after the request; a clear takes long in slow mode.
	always @(posedge clk_sys) begin
		nvmDone <= (doneCnt == 8'h01);
		if (nvmProtoWrite) begin
			storedProto   <= protocolSel;
			nvmProtoValid <= 1'b1;
		end
		if (nvmPortSave) begin
			storedMode      <= portMode;
			nvmPortCfgValid <= 1'b1;
		end
		if (nvmClearReq) begin
			nvmProtoValid   <= 1'b0;
			nvmPortCfgValid <= 1'b0;
			doneCnt         <= slowDone ? 8'h28 : 8'h02;
		end else if (doneCnt != 8'h00) begin
			doneCnt <= doneCnt - 8'h01;
		end
	end
endmodule
